// ===== rtl/mic_irq_ctrl.sv
// interrupt request, enable, priority and vectoring logic with apb registers
// Notes on behaviour
// [R1] first register bits 0..3: global, pin, timer0, timer1 enables, reset zero
// [R2] first register bits 4..6: pin, timer0, timer1 flags; bit 7 reads zero
// [R3] second register: time base flag bit 5, enable bit 1; bits 7,6 zero
// [R4] converter variant: conversion flag bit 4, enable bit 0; bits 3,2 zero
// [R5] plain variant: second register bits 4..2 and bit 0 read zero
// [R6] timer request serviced only with global and its own enable set
// [R7] timer overflow sets that timer's request flag
// [R8] enabled timer request with stack not full calls the timer vector
// [R9] timer service clears its flag and the global enable
// [R10] time base overflow sets its flag; serviced with global and own enable
// [R11] time base service calls its vector, clears its flag and global enable
// [R12] flags stay pending while disabled, until serviced or cleared by software
// [R13] every source can wake the processor from sleep
// [R14] only the program counter is pushed; core does this on the call
// [R15] software should avoid nested calls and save its own registers
// [R16] priority and vectors: pin 04, timer0 08, timer1 0C, conversion 10, time base 14
// [R17] pin edge select: 00 off, 01 rising, 10 falling, 11 both
// [R18] request to call takes 2 or 3 instruction cycles, 3 from sleep
// [R19] conversion done sets its flag; service clears it and global enable
`timescale 1ns/1ps
`default_nettype none
module mic_irq_ctrl #(
    parameter bit HAS_CONV = 1'b1
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire mic_pkg::mic_apb_req_t  apb_req,
    output      mic_pkg::mic_apb_rsp_t  apb_rsp,
    input  wire mic_pkg::mic_events_t   events,
    input  wire logic                   ext_pin,
    input  wire logic                   stack_full,
    input  wire logic                   sleeping,
    input  wire logic                   call_ack,
    output      mic_pkg::mic_core_out_t core_out,
    output      logic                   irq
);
    import mic_pkg::*;

    mic_state_reg_t s_r;
    mic_state_reg_t s_nxt;

    function automatic mic_src_t pick(input logic [4:0] req);
        mic_src_t r;
        r = SRC_NONE;
        for (int i = 4; i >= 0; i--) begin
            if (req[i]) begin
                r = mic_src_t'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] vec_of(input mic_src_t s);
        logic [7:0] v;
        unique case (s)
            SRC_PIN:  v = VEC_PIN;
            SRC_T0:   v = VEC_T0;
            SRC_T1:   v = VEC_T1;
            SRC_CONV: v = VEC_CONV;
            SRC_TB:   v = VEC_TB;
            default:  v = RESET_BYTE;
        endcase
        return v;
    endfunction

    logic [7:0] mask_second;
    logic [7:0] rd_first;
    logic [7:0] rd_second;
    logic [4:0] flags;
    logic [4:0] enables;
    logic [4:0] pending;
    logic       pin_edge;
    logic       wr;
    logic       rd;
    logic       addr_ok;

    assign mask_second = HAS_CONV ? MASK_SECOND_ADC : MASK_SECOND_PLN; // R4 R5
    assign rd_first  = {1'b0, s_r.ctrl_first}; // R2
    assign rd_second = {2'b00, s_r.ctrl_second} & mask_second; // R3 R4 R5
    assign flags   = {rd_second[BIT_TB_FLAG], rd_second[BIT_CONV_FLAG],
                      rd_first[BIT_T1_FLAG], rd_first[BIT_T0_FLAG], rd_first[BIT_PIN_FLAG]};
    assign enables = {rd_second[BIT_TB_EN], rd_second[BIT_CONV_EN],
                      rd_first[BIT_T1_EN], rd_first[BIT_T0_EN], rd_first[BIT_PIN_EN]};
    // flags pend regardless of enable; enable gates service and wake
    assign pending = flags & enables; // R6 R10 R12
    assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign rd = apb_req.psel & ~apb_req.pwrite & ~apb_req.penable;
    assign addr_ok = (apb_req.paddr == ADDR_CTRL_FIRST) || (apb_req.paddr == ADDR_CTRL_SECOND)
                  || (apb_req.paddr == ADDR_EDGE_SEL) || (apb_req.paddr == ADDR_STATUS)
                  || (apb_req.paddr == ADDR_MASK) || (apb_req.paddr == ADDR_VECTOR);

    always_comb begin
        unique case (s_r.edge_sel) // R17
            EDGE_RISE: pin_edge = s_r.pin_s2 & ~s_r.pin_prev;
            EDGE_FALL: pin_edge = ~s_r.pin_s2 & s_r.pin_prev;
            EDGE_BOTH: pin_edge = s_r.pin_s2 ^ s_r.pin_prev;
            EDGE_OFF:  pin_edge = 1'b0;
        endcase
    end

    always_comb begin
        logic [7:0] f;
        logic [7:0] sec;
        logic [4:0] ev;
        logic       svc;
        s_nxt = s_r;
        s_nxt.pin_s1   = ext_pin;
        s_nxt.pin_s2   = s_r.pin_s1;
        s_nxt.pin_prev = s_r.pin_s2;
        s_nxt.phase    = s_r.phase + 2'h1;
        f   = rd_first;
        sec = rd_second;
        svc = (s_r.state == ST_CALL) && call_ack;
        ev  = {events.tb_ovf, events.conv_done & HAS_CONV, events.t1_ovf, events.t0_ovf, pin_edge};

        // software writes first, then service clear, then hardware set
        if (wr) begin
            unique case (apb_req.paddr)
                ADDR_CTRL_FIRST:  f = apb_req.pwdata[7:0] & MASK_FIRST; // R1 R2
                ADDR_CTRL_SECOND: sec = apb_req.pwdata[7:0] & mask_second; // R3 R4 R5
                ADDR_EDGE_SEL: s_nxt.edge_sel = apb_req.pwdata[BIT_EDGE_HI:BIT_EDGE_LO];
                ADDR_STATUS: s_nxt.status = s_r.status & ~apb_req.pwdata[4:0];
                ADDR_MASK:   s_nxt.mask = apb_req.pwdata[4:0];
                default: ;
            endcase
        end
        if (svc) begin
            f[BIT_GLOBAL_EN] = 1'b0; // R9 R11 R19
            unique case (s_r.src)
                SRC_PIN:  f[BIT_PIN_FLAG] = 1'b0;
                SRC_T0:   f[BIT_T0_FLAG] = 1'b0; // R9
                SRC_T1:   f[BIT_T1_FLAG] = 1'b0; // R9
                SRC_CONV: sec[BIT_CONV_FLAG] = 1'b0; // R19
                SRC_TB:   sec[BIT_TB_FLAG] = 1'b0; // R11
                default: ;
            endcase
        end
        // hardware set wins over any clear in the same cycle
        if (pin_edge)         f[BIT_PIN_FLAG] = 1'b1;
        if (events.t0_ovf)    f[BIT_T0_FLAG] = 1'b1; // R7
        if (events.t1_ovf)    f[BIT_T1_FLAG] = 1'b1; // R7
        if (events.tb_ovf)    sec[BIT_TB_FLAG] = 1'b1; // R10
        if (events.conv_done && HAS_CONV) sec[BIT_CONV_FLAG] = 1'b1; // R19
        s_nxt.ctrl_first  = f[6:0];
        s_nxt.ctrl_second = sec[5:0] & mask_second[5:0];

        s_nxt.status = s_nxt.status | (ev & MASK_EVENTS);

        s_nxt.call_req = 1'b0;
        unique case (s_r.state) // R18
            ST_IDLE: begin
                if (rd_first[BIT_GLOBAL_EN] && (pending != 5'h00)) begin // R6 R10
                    s_nxt.state      = ST_WAIT;
                    s_nxt.instr_cnt  = 2'h0;
                    s_nxt.lat_target = sleeping ? LAT_SLEEP : LAT_AWAKE; // R13 R18
                end
            end
            ST_WAIT: begin
                if (!rd_first[BIT_GLOBAL_EN] || pending == 5'h00) begin
                    s_nxt.state = ST_IDLE;
                end else if (s_r.phase == PHASE_LAST) begin
                    // widened so a count saturated behind a full stack cannot wrap to zero
                    if (({1'b0, s_r.instr_cnt} + 3'h1 >= {1'b0, s_r.lat_target})
                        && !stack_full) begin // R8
                        s_nxt.state       = ST_CALL;
                        s_nxt.src         = pick(pending); // R16
                        s_nxt.call_vector = vec_of(pick(pending)); // R16
                        s_nxt.call_req    = 1'b1;
                    end else if (s_r.instr_cnt != LAT_SLEEP) begin
                        s_nxt.instr_cnt = s_r.instr_cnt + 2'h1;
                    end
                end
            end
            ST_CALL: begin
                // core pushes only the program counter on this acknowledge
                s_nxt.call_req = ~call_ack; // R14
                if (call_ack) begin
                    s_nxt.state       = ST_IDLE;
                    s_nxt.last_vector = s_r.call_vector;
                end
            end
        endcase

        s_nxt.prdata = APB_ZERO;
        if (rd) begin
            unique case (apb_req.paddr)
                ADDR_CTRL_FIRST:  s_nxt.prdata = {24'h00_0000, rd_first};
                ADDR_CTRL_SECOND: s_nxt.prdata = {24'h00_0000, rd_second};
                ADDR_EDGE_SEL: s_nxt.prdata = {24'h00_0000, s_r.edge_sel, 6'h00};
                ADDR_STATUS:   s_nxt.prdata = {27'h000_0000, s_r.status};
                ADDR_MASK:     s_nxt.prdata = {27'h000_0000, s_r.mask};
                ADDR_VECTOR:   s_nxt.prdata = {24'h00_0000, s_r.last_vector};
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // no wait state: read data is registered in the setup cycle
    assign apb_rsp.pready  = apb_req.psel & apb_req.penable;
    assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~addr_ok;
    assign apb_rsp.prdata  = s_r.prdata;
    assign core_out.call_req    = s_r.call_req;
    assign core_out.call_vector = s_r.call_vector;
    // wake ignores the global enable so a sleeping core is roused by any enabled flag
    assign core_out.wake = sleeping & (pending != 5'h00); // R13
    assign irq = (s_r.status & s_r.mask) != 5'h00;

    a_timer_set: assert property (@(posedge pclk) disable iff (!presetn)
        events.t0_ovf |=> s_r.ctrl_first[BIT_T0_FLAG]) // R7
        else $error("timer0 flag not set after overflow");
    a_tb_set: assert property (@(posedge pclk) disable iff (!presetn)
        events.tb_ovf |=> s_r.ctrl_second[BIT_TB_FLAG]) // R10
        else $error("time base flag not set");
    a_svc_clears_gie: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.state == ST_CALL && call_ack) |=> !s_r.ctrl_first[BIT_GLOBAL_EN]) // R9
        else $error("global enable not cleared on service");
    a_tb_svc_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.state == ST_CALL && call_ack && s_r.src == SRC_TB && !events.tb_ovf)
        |=> !s_r.ctrl_second[BIT_TB_FLAG]) // R11
        else $error("time base flag not cleared on service");
    a_call_enabled: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(s_r.call_req) |-> $past(rd_first[BIT_GLOBAL_EN]) && !$past(stack_full)) // R6
        else $error("call issued while disabled or stack full");
    a_pin_vector: assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(s_r.call_req) && s_r.src == SRC_PIN) |-> s_r.call_vector == VEC_PIN) // R16
        else $error("wrong pin vector");
    a_bit7_zero: assert property (@(posedge pclk) disable iff (!presetn)
        !rd_first[7] && rd_second[7:6] == 2'b00 && rd_second[3:2] == 2'b00) // R2
        else $error("unimplemented bits read nonzero");
    a_plain_zero: assert property (@(posedge pclk) disable iff (!presetn)
        !HAS_CONV |-> (rd_second[4] == 1'b0 && rd_second[0] == 1'b0)) // R5
        else $error("plain variant bits nonzero");
    a_flag_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.ctrl_first[BIT_T1_FLAG] && !wr && s_r.state != ST_CALL)
        |=> s_r.ctrl_first[BIT_T1_FLAG]) // R12
        else $error("timer1 flag lost while pending");
    a_latency_min: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.state == ST_IDLE && s_nxt.state == ST_WAIT) |=> !s_r.call_req [*5]) // R18
        else $error("call faster than two instruction cycles");

    c_timer_call: cover property (@(posedge pclk) s_r.call_req && s_r.src == SRC_T0);
    c_tb_call: cover property (@(posedge pclk) s_r.call_req && s_r.src == SRC_TB);
    c_sleep_wake: cover property (@(posedge pclk) core_out.wake);
    c_irq_out: cover property (@(posedge pclk) irq);
endmodule
`default_nettype wire

// ===== rtl/mic_pkg.sv
// package for the microcontroller interrupt controller: register map, fields, timing
package mic_pkg;
    // apb byte addresses
    localparam logic [7:0] ADDR_CTRL_FIRST  = 8'h00;
    localparam logic [7:0] ADDR_CTRL_SECOND = 8'h04;
    localparam logic [7:0] ADDR_EDGE_SEL    = 8'h08;
    localparam logic [7:0] ADDR_STATUS      = 8'h0C;
    localparam logic [7:0] ADDR_MASK        = 8'h10;
    localparam logic [7:0] ADDR_VECTOR      = 8'h14;

    // first control register fields
    localparam int BIT_GLOBAL_EN  = 0;
    localparam int BIT_PIN_EN     = 1;
    localparam int BIT_T0_EN      = 2;
    localparam int BIT_T1_EN      = 3;
    localparam int BIT_PIN_FLAG   = 4;
    localparam int BIT_T0_FLAG    = 5;
    localparam int BIT_T1_FLAG    = 6;
    // second control register fields
    localparam int BIT_CONV_EN    = 0;
    localparam int BIT_TB_EN      = 1;
    localparam int BIT_CONV_FLAG  = 4;
    localparam int BIT_TB_FLAG    = 5;
    // edge select field position
    localparam int BIT_EDGE_LO    = 6;
    localparam int BIT_EDGE_HI    = 7;

    // implemented-bit masks
    localparam logic [7:0] MASK_FIRST      = 8'h7F;
    localparam logic [7:0] MASK_SECOND_ADC = 8'h33;
    localparam logic [7:0] MASK_SECOND_PLN = 8'h22;
    localparam logic [7:0] MASK_EDGE       = 8'hC0;
    localparam logic [4:0] MASK_EVENTS     = 5'h1F;
    localparam logic [7:0] RESET_BYTE      = 8'h00;

    // vectors, by source
    localparam logic [7:0] VEC_PIN  = 8'h04;
    localparam logic [7:0] VEC_T0   = 8'h08;
    localparam logic [7:0] VEC_T1   = 8'h0C;
    localparam logic [7:0] VEC_CONV = 8'h10;
    localparam logic [7:0] VEC_TB   = 8'h14;

    // edge select codes
    localparam logic [1:0] EDGE_OFF  = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // one instruction cycle is four system clocks
    localparam int          CLK_MHZ       = 40;
    localparam int          SYS_PER_INSTR = 4;
    localparam logic [1:0]  PHASE_LAST    = 2'(SYS_PER_INSTR - 1);
    localparam logic [1:0]  LAT_AWAKE     = 2'h2;
    localparam logic [1:0]  LAT_SLEEP     = 2'h3;

    localparam logic [31:0] APB_ZERO = 32'h0000_0000;

    // event index order is also priority order
    typedef enum logic [2:0] {
        SRC_PIN, SRC_T0, SRC_T1, SRC_CONV, SRC_TB, SRC_NONE
    } mic_src_t;

    typedef enum logic [1:0] {
        ST_IDLE, ST_WAIT, ST_CALL
    } mic_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } mic_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } mic_apb_rsp_t;

    // event strobes from peripherals, one cycle each
    typedef struct packed {
        logic tb_ovf;
        logic conv_done;
        logic t1_ovf;
        logic t0_ovf;
    } mic_events_t;

    // core side: request out, acknowledge in
    typedef struct packed {
        logic       call_req;
        logic [7:0] call_vector;
        logic       wake;
    } mic_core_out_t;

    typedef struct packed {
        logic [6:0] ctrl_first;
        logic [5:0] ctrl_second;
        logic [1:0] edge_sel;
        logic [4:0] status;
        logic [4:0] mask;
        logic [7:0] last_vector;
        logic       pin_s1;
        logic       pin_s2;
        logic       pin_prev;
        mic_state_t state;
        logic [1:0] phase;
        logic [1:0] instr_cnt;
        logic [1:0] lat_target;
        mic_src_t   src;
        logic       call_req;
        logic [7:0] call_vector;
        logic [31:0] prdata;
    } mic_state_reg_t;
endpackage

// ===== verif/mic_core_model.sv
// processor core model: acknowledges vectored calls, recording the vector and a call count
`timescale 1ns/1ps
`default_nettype none
module mic_core_model (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire mic_pkg::mic_core_out_t core_out,
    input  wire logic                   full_mode,
    input  wire logic                   sleep_mode,
    input  wire logic [3:0]             ack_wait,
    output logic                        call_ack,
    output logic                        stack_full,
    output logic                        sleeping,
    output logic [7:0]                  vec_r,
    output logic [7:0]                  calls_r
);
    import mic_pkg::*;
    logic       ack_r;
    logic [3:0] wait_r;
    // the bench decides when the stack is full or the core sleeps
    assign stack_full = full_mode;
    assign sleeping   = sleep_mode;
    assign call_ack   = ack_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_r   <= 1'b0;
            wait_r  <= 4'h0;
            vec_r   <= 8'h00;
            calls_r <= 8'h00;
        end else if (ack_r) begin
            // one-cycle acknowledge; service code never nests calls
            ack_r  <= 1'b0;
            wait_r <= 4'h0;
        end else if (core_out.call_req && !stack_full) begin
            if (wait_r >= ack_wait) begin
                // only the program counter goes on the stack
                ack_r   <= 1'b1;
                vec_r   <= core_out.call_vector;
                calls_r <= calls_r + 8'h01;
            end else begin
                wait_r <= wait_r + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verif/mic_irq_ctrl_tb_top.sv
// self-checking bench for the interrupt controller: registers, flags, priority, latency
`timescale 1ns/1ps
`default_nettype none
module mic_irq_ctrl_tb_top;
    import mic_pkg::*;
    logic          pclk;
    logic          presetn;
    mic_apb_req_t  apb_req;
    mic_apb_rsp_t  apb_rsp;
    mic_apb_rsp_t  rsp_plain;
    mic_events_t   events;
    mic_core_out_t core_out;
    logic          ext_pin;
    logic          stack_full;
    logic          sleeping;
    logic          call_ack;
    logic          irq;
    logic          full_mode;
    logic          sleep_mode;
    logic [3:0]    ack_wait;
    logic [7:0]    vec_r;
    logic [7:0]    calls_r;
    logic [31:0]   q;
    logic [31:0]   q2;
    logic          e;
    int            n;
    int            n_fail;
    int            samples_checked;
    logic [7:0]    t_addr [5] = '{ADDR_CTRL_FIRST, ADDR_CTRL_SECOND, ADDR_EDGE_SEL, ADDR_MASK,
                                  ADDR_VECTOR};
    logic [7:0]    t_exp [5]  = '{MASK_FIRST, MASK_SECOND_ADC, MASK_EDGE, 8'h1F, 8'h00};
    logic [7:0]    v_exp [5]  = '{VEC_PIN, VEC_T0, VEC_T1, VEC_CONV, VEC_TB};

    mic_irq_ctrl #(.HAS_CONV(1'b1)) u_dut (
        .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .events(events), .ext_pin(ext_pin), .stack_full(stack_full), .sleeping(sleeping),
        .call_ack(call_ack), .core_out(core_out), .irq(irq));
    // variant without converter, watched only through its register reads
    mic_irq_ctrl #(.HAS_CONV(1'b0)) u_plain (
        .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(rsp_plain),
        .events(events), .ext_pin(ext_pin), .stack_full(1'b1), .sleeping(1'b0),
        .call_ack(1'b0), .core_out(), .irq());
    mic_core_model u_core (
        .pclk(pclk), .presetn(presetn), .core_out(core_out), .full_mode(full_mode),
        .sleep_mode(sleep_mode), .ack_wait(ack_wait), .call_ack(call_ack),
        .stack_full(stack_full), .sleeping(sleeping), .vec_r(vec_r), .calls_r(calls_r));

    initial pclk = 1'b0;
    always #12.5 pclk = ~pclk;

    task automatic tally_and_finish();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // setup, then access held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        apb_req.psel    <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite  <= wr;
        apb_req.paddr   <= a;
        apb_req.pwdata  <= d;
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        @(posedge pclk);
        while (apb_rsp.pready !== 1'b1) @(posedge pclk);
        q  = apb_rsp.prdata;
        q2 = rsp_plain.prdata;
        e  = apb_rsp.pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic pulse(input logic [3:0] ev);
        events <= mic_events_t'(ev);
        @(posedge pclk);
        events <= mic_events_t'(4'h0);
    endtask

    // sleeping changes how long a request takes to become a call
    task automatic lat(input logic s, input int lo, input int hi);
        sleep_mode <= s;
        apb(1'b1, ADDR_CTRL_FIRST, 32'h0000_0005);
        pulse(4'h1);
        n = 0;
        while (core_out.call_req !== 1'b1) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(n >= lo && n <= hi), 32'h0000_0001);
        chk(32'(core_out.wake), 32'(s));
        while (core_out.call_req === 1'b1) @(posedge pclk);
        sleep_mode <= 1'b0;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        presetn = 1'b0;
        apb_req = '0;
        events = '0;
        ext_pin = 1'b0;
        full_mode = 1'b1;
        sleep_mode = 1'b0;
        ack_wait = 4'h0;
        n_fail = 0;
        samples_checked = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 8'(4 * i), APB_ZERO);
            chk(q, APB_ZERO);
        end
        apb(1'b0, 8'h18, APB_ZERO);
        chk(32'(e), 32'h0000_0001);
        // stack held full so software-set flags cannot be serviced here
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, t_addr[i], 32'hFFFF_FFFF);
            apb(1'b0, t_addr[i], APB_ZERO);
            chk(q, 32'(t_exp[i]));
            if (i == 1) chk(q2, 32'(MASK_SECOND_PLN));
            apb(1'b1, t_addr[i], APB_ZERO);
        end
        apb(1'b1, ADDR_STATUS, 32'h0000_001F);
        pulse(4'hF);
        repeat (20) @(posedge pclk);
        apb(1'b0, ADDR_CTRL_FIRST, APB_ZERO);
        chk(q, 32'h0000_0060);
        apb(1'b0, ADDR_CTRL_SECOND, APB_ZERO);
        chk(q, 32'h0000_0030);
        apb(1'b0, ADDR_STATUS, APB_ZERO);
        chk(q, 32'h0000_001E);
        chk(32'(irq), APB_ZERO);
        apb(1'b1, ADDR_MASK, 32'h0000_0004);
        chk(32'(irq), 32'h0000_0001);
        apb(1'b1, ADDR_STATUS, 32'h0000_0004);
        chk(32'(irq), APB_ZERO);
        full_mode <= 1'b0;
        apb(1'b1, ADDR_CTRL_FIRST, 32'h0000_0064);
        repeat (40) @(posedge pclk);
        chk(32'(calls_r), APB_ZERO);
        // leftover enables and flags would spoil the pin flag reads below
        apb(1'b1, ADDR_CTRL_FIRST, APB_ZERO);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ADDR_EDGE_SEL, 32'(i << 6));
            for (int j = 0; j < 2; j++) begin
                ext_pin <= ~ext_pin;
                repeat (6) @(posedge pclk);
                apb(1'b0, ADDR_CTRL_FIRST, APB_ZERO);
                chk(q, 32'(((i >> j) & 1) << 4));
                apb(1'b1, ADDR_CTRL_FIRST, APB_ZERO);
            end
        end
        full_mode <= 1'b1;
        apb(1'b1, ADDR_EDGE_SEL, 32'h0000_0040);
        apb(1'b1, ADDR_CTRL_SECOND, 32'h0000_0003);
        apb(1'b1, ADDR_CTRL_FIRST, 32'h0000_000F);
        ext_pin <= 1'b1;
        pulse(4'hF);
        repeat (40) @(posedge pclk);
        chk(32'(calls_r), APB_ZERO);
        full_mode <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            while (calls_r !== 8'(i + 1)) @(posedge pclk);
            chk(32'(vec_r), 32'(v_exp[i]));
            apb(1'b0, ADDR_CTRL_FIRST, APB_ZERO);
            chk(32'(q[0]), APB_ZERO);
            apb(1'b1, ADDR_CTRL_FIRST, q | 32'h0000_0001);
        end
        apb(1'b0, ADDR_CTRL_FIRST, APB_ZERO);
        chk(q, 32'h0000_000F);
        apb(1'b0, ADDR_CTRL_SECOND, APB_ZERO);
        chk(q, 32'h0000_0003);
        apb(1'b0, ADDR_VECTOR, APB_ZERO);
        chk(q, 32'(VEC_TB));
        ack_wait <= 4'h3;
        // counts start after the flag capture edge and include the edge at which call_req is seen
        lat(1'b0, 7, 10);
        lat(1'b1, 11, 14);
        tally_and_finish();
    end
endmodule
`default_nettype wire
